// File: pkg/pcrsm_defs.vh
// Constants for the power, clock, reset and sleep manager core.
`ifndef PCRSM_DEFS_VH
`define PCRSM_DEFS_VH
// System bus mask bit positions.
`define PCRSM_AHB_HPB0 0
`define PCRSM_AHB_HPB1 1
`define PCRSM_AHB_HPB2 2
`define PCRSM_AHB_DBG 3
`define PCRSM_AHB_FLASH 4
`define PCRSM_AHB_RESET 5'h1f
// Peripheral bus A mask positions: group0, pm, system_control_unit, gclk, wdt, rtc, eic.
`define PCRSM_APBA_PM 1
`define PCRSM_APBA_RESET 7'h7f
// Peripheral bus B mask: group1, debug, flash, port.
`define PCRSM_APBB_RESET 4'hf
// Peripheral bus C mask: group2, evsys, serial 0-5, timers 0-7, adc, ac, dac, touch.
`define PCRSM_APBC_RESET 20'h10000
// Reset cause bit positions.
`define PCRSM_RC_POR 3'h0
`define PCRSM_RC_CBOD 3'h1
`define PCRSM_RC_SBOD 3'h2
`define PCRSM_RC_EXT 3'h4
`define PCRSM_RC_WDT 3'h5
`define PCRSM_RC_SYST 3'h6
`define PCRSM_RC_RESET 8'h01
// Reference clock and system clock frequencies in Hz.
`define PCRSM_REF_HZ 32768
`define PCRSM_CLK_HZ 50000000
`endif

// File: testbench/pcrsm_checker.sv
// Port-level assertions for the power manager core.
`timescale 1ns/10ps
module pcrsm_checker
(
   input wire clock,
   input wire sys_rst,
   input wire apbaMaskWr,
   input wire [6:0] apbaMaskData,
   input wire [6:0] apbaMask_ff,
   input wire apbcMaskWr,
   input wire [19:0] apbcMask_ff,
   input wire [19:0] apbcClkEn,
   input wire maskLocked,
   input wire clock_fail_flag_ff,
   input wire clockFailFlagClr,
   input wire clockFailIntEn,
   input wire clockFailIrq,
   input wire sleeping,
   input wire lowPowerMode,
   input wire cpuClkEn,
   input wire apbClkRun,
   input wire mainClkRun,
   input wire asyncIrq
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (sys_rst);
   chk_irq_tie: assert property (clockFailIrq == (clock_fail_flag_ff && clockFailIntEn))
      else $error("irq not flag and enable");
   chk_mask_write: assert property (apbaMaskWr && !maskLocked |=> apbaMask_ff == $past(apbaMaskData))
      else $error("mask write lost");
   chk_lock_refuse: assert property (maskLocked && apbcMaskWr |=> $stable(apbcMask_ff))
      else $error("locked mask changed");
   chk_lock_hold: assert property (maskLocked |=> maskLocked)
      else $error("lock released");
   chk_flag_hold: assert property (clock_fail_flag_ff && !clockFailFlagClr |=> clock_fail_flag_ff)
      else $error("fail flag dropped");
   chk_standby_stop: assert property (sleeping && lowPowerMode |-> !cpuClkEn && !apbClkRun && !mainClkRun)
      else $error("standby clock running");
   chk_domain_halt: assert property (!apbClkRun |-> apbcClkEn == 20'h00000)
      else $error("halted domain clocked");
   chk_async_wake: assert property (sleeping && asyncIrq |=> !sleeping)
      else $error("no wake on async irq");
   chk_deep_hold: assert property (sleeping && !apbClkRun && !asyncIrq |=> sleeping)
      else $error("woke without async irq");
endmodule // pcrsm_checker

// File: testbench/pcrsm_osc_model.sv
// Oscillator model: main clock and reference clock edge pulses.
`timescale 1ns/10ps
module pcrsm_osc_model
#(
   parameter REF_DIV = 16
)
(
   input wire clock,
   input wire stopMain,
   output reg mainClkEdge,
   output reg refClkEdge
);
   reg [7:0] cnt_ff = 8'h00;
   always @(posedge clock)
   begin
      cnt_ff <= (cnt_ff == REF_DIV - 1) ? 8'h00 : cnt_ff + 8'h01;
      refClkEdge <= (cnt_ff == 8'h00);
      mainClkEdge <= !stopMain && cnt_ff[0];
   end
endmodule // pcrsm_osc_model

// File: testbench/power_clock_reset_sleep_manager_test.sv
// Self-checking bench for the power manager core.
`timescale 1ns/10ps
module power_clock_reset_sleep_manager_test;
reg clock, sys_rst, ahbMaskWr, apbaMaskWr, apbbMaskWr, apbcMaskWr, apbaBridgeOn, stopMain;
reg [4:0] ahbMaskData;
reg [6:0] apbaMaskData;
reg [3:0] apbbMaskData;
reg [19:0] apbcMaskData;
reg clock_fail_detect_enable, mainClkReady, backupClrWr, clockFailFlagClr, clockFailIntEn;
reg porRst, core_brownout_detector, supply_brownout_detector, resetPin_n, wdtRst;
reg cpu_software_reset_request, wait_for_interrupt_instr, handlerExitLowest;
reg sleep_after_handler, deep_sleep_select, run_in_standby, on_request_only, oscRequest;
reg syncAhbIrq, syncApbIrq, asyncIrq;
reg [1:0] idleLevel;
wire [4:0] system_bus_clock_mask_ff, ahbClkEn;
wire [6:0] apbaMask_ff, apbaClkEn;
wire [3:0] apbbMask_ff, apbbClkEn;
wire [19:0] apbcMask_ff, apbcClkEn;
wire [7:0] reset_cause_register_ff;
wire maskLocked, mainClkEdge, refClkEdge, backup_clock_select_ff, clock_fail_flag_ff;
wire clockFailIrq, powerDomainRst, debugDomainRst, userDomainRst, cpuClkEn, ahbClkRun;
wire apbClkRun, mainClkRun, oscRun, lowPowerMode, sleeping;
integer nMismatch = 0;
integer samplesChecked = 0;
integer i;
pcrsm_power_manager dut_u (.*);
pcrsm_osc_model #(.REF_DIV(16)) osc_u (.clock(clock), .stopMain(stopMain),
   .mainClkEdge(mainClkEdge), .refClkEdge(refClkEdge));
task print_verdict;
begin
   if (nMismatch == 0 && samplesChecked > 0)
      $display("Test passed");
   else
      $display("Test failed");
   $finish;
end
endtask
task chk(input [31:0] got, input [31:0] exp, input [8*8:1] nm);
begin
   samplesChecked = samplesChecked + 1;
   if (got !== exp)
   begin
      nMismatch = nMismatch + 1;
      $display("MISMATCH %0s exp %0h got %0h", nm, exp, got);
   end
end
endtask
task wrc(input [19:0] d);
begin
   @(posedge clock) apbcMaskWr <= 1'b1;
   apbcMaskData <= d;
   @(posedge clock) apbcMaskWr <= 1'b0;
   @(negedge clock);
end
endtask
task t_masks;
begin
   chk(apbcMask_ff, 20'h10000, "apbc");
   chk(apbaMask_ff, 7'h7f, "apba");
   chk(reset_cause_register_ff, 8'h01, "cause");
   @(posedge clock) ahbMaskWr <= 1'b1;
   ahbMaskData <= 5'h0f;
   @(posedge clock) ahbMaskWr <= 1'b0;
   wrc(20'h00003);
   chk(apbcClkEn, 20'h00003, "apbcen");
   chk({system_bus_clock_mask_ff, apbbMask_ff}, 9'h0ff, "ahbapbb");
   @(posedge clock) apbaMaskWr <= 1'b1;
   apbaMaskData <= 7'h7d;
   @(posedge clock) apbaMaskWr <= 1'b0;
   wrc(20'h00000);
   chk({maskLocked, apbcMask_ff}, 21'h100003, "locked");
   @(posedge clock) sys_rst <= 1'b1;
   @(posedge clock) sys_rst <= 1'b0;
   @(negedge clock) chk({maskLocked, apbcMask_ff}, 21'h010000, "unlock");
end
endtask
task t_cfd;
begin
   @(posedge clock) clock_fail_detect_enable <= 1'b1;
   clockFailIntEn <= 1'b1;
   repeat (48) @(negedge clock);
   chk(clock_fail_flag_ff, 1'b0, "nofail");
   @(posedge clock) {stopMain, mainClkReady} <= 2'h2;
   repeat (48) @(negedge clock);
   chk(clock_fail_flag_ff, 1'b0, "suspend");
   @(posedge clock) mainClkReady <= 1'b1;
   for (i = 0; i < 64 && clock_fail_flag_ff !== 1'b1; i = i + 1)
      @(negedge clock);
   if (i == 64)
   begin
      nMismatch = nMismatch + 1;
      print_verdict;
   end
   chk({backup_clock_select_ff, clockFailIrq}, 2'h3, "fail");
   // Restore main and disable the detector with the backup clear, so it cannot fail main again.
   @(posedge clock) stopMain <= 1'b0;
   clock_fail_detect_enable <= 1'b0;
   backupClrWr <= 1'b1;
   @(posedge clock) backupClrWr <= 1'b0;
   @(negedge clock) chk({backup_clock_select_ff, clock_fail_flag_ff}, 2'h1, "bkclr");
   @(posedge clock) clockFailFlagClr <= 1'b1;
   @(posedge clock) clockFailFlagClr <= 1'b0;
   @(negedge clock) chk({clock_fail_flag_ff, clockFailIrq}, 2'h0, "flagclr");
end
endtask
task t_sleep;
begin
   for (i = 0; i < 5; i = i + 1)
   begin
      @(posedge clock) idleLevel <= (i > 3) ? 2'h0 : i;
      deep_sleep_select <= (i == 3);
      run_in_standby <= (i == 3);
      sleep_after_handler <= (i == 4);
      wait_for_interrupt_instr <= (i < 4);
      handlerExitLowest <= (i == 4);
      @(posedge clock) {wait_for_interrupt_instr, handlerExitLowest} <= 2'h0;
      @(negedge clock) chk({sleeping, cpuClkEn}, 2'h2, "enter");
      chk({ahbClkRun, apbClkRun}, {i == 0 || i == 4, i < 2 || i == 4}, "idle");
      chk({lowPowerMode, mainClkRun, oscRun}, {i == 3, i != 3, 1'b1}, "stby");
      if (i == 1 || i == 2)
      begin
         @(posedge clock) syncAhbIrq <= (i == 1);
         syncApbIrq <= (i == 2);
         @(posedge clock);
         @(negedge clock) chk(sleeping, 1'b1, "nowake");
      end
      @(posedge clock) syncAhbIrq <= (i == 0);
      syncApbIrq <= (i == 1);
      asyncIrq <= (i > 1);
      @(posedge clock);
      @(negedge clock) chk({sleeping, cpuClkEn}, 2'h1, "wake");
      @(posedge clock) {syncAhbIrq, syncApbIrq, asyncIrq} <= 3'h0;
   end
end
endtask
task t_rst;
begin
   for (i = 0; i < 6; i = i + 1)
   begin
      @(posedge clock) {wdtRst, cpu_software_reset_request} <= {i == 4, i == 5};
      {porRst, core_brownout_detector, supply_brownout_detector} <= {i == 0, i == 1, i == 2};
      resetPin_n <= (i != 3);
      @(negedge clock) chk({powerDomainRst, debugDomainRst, userDomainRst},
         {i < 3, i < 4, 1'b1}, "scope");
      @(posedge clock) {porRst, core_brownout_detector, supply_brownout_detector} <= 3'h0;
      {wdtRst, cpu_software_reset_request, resetPin_n} <= 3'h1;
      @(negedge clock) chk(reset_cause_register_ff, 8'h01 << (i < 3 ? i : i + 1), "cause");
   end
end
endtask
initial
begin
   clock = 1'b0;
   forever #10 clock = ~clock;
end
initial
begin
   {ahbMaskWr, apbaMaskWr, apbbMaskWr, apbcMaskWr, ahbMaskData, apbaMaskData} = 0;
   {apbbMaskData, apbcMaskData, stopMain, clock_fail_detect_enable, backupClrWr} = 0;
   {clockFailFlagClr, clockFailIntEn, core_brownout_detector, supply_brownout_detector} = 0;
   {wdtRst, cpu_software_reset_request, wait_for_interrupt_instr, handlerExitLowest} = 0;
   {sleep_after_handler, deep_sleep_select, run_in_standby, on_request_only, oscRequest} = 0;
   {syncAhbIrq, syncApbIrq, asyncIrq, idleLevel} = 0;
   {sys_rst, porRst, resetPin_n, mainClkReady, apbaBridgeOn} = 5'h1f;
   repeat (10) @(posedge clock);
   {sys_rst, porRst} <= 2'h0;
   @(negedge clock);
   t_masks;
   t_cfd;
   t_sleep;
   t_rst;
   print_verdict;
end
endmodule // power_clock_reset_sleep_manager_test
bind pcrsm_power_manager pcrsm_checker chk_u (.*);

// File: verilog/pcrsm_power_manager.v
// Power manager core: clock masks, clock failure detector, reset cause, sleep control.
// Overview of operation
// - Masked peripheral bus clock blocks register access; writing one restores clock.
// - Modules on two domains get one mask bit per domain.
// - Masking manager or bridge clock locks masks until system reset.
// - Fail main clock if no rising edge within a 32 kHz period.
// - Enable bit set starts monitoring undivided main clock while it stays set.
// - On failure switch to 8 MHz backup, set flag, request interrupt if enabled.
// - Hardware sets backup select; writing zero reselects main, failure stays.
// - Detector suspends while main clock unavailable or in any sleep mode.
// - Reset cause register holds source of most recent reset.
// - Power resets reset all; external spares 32k domain; user spares debug too.
// - Low reset pin causes external reset.
// - CPU reset request bit produces a software reset, a user reset.
// - Wait-for-interrupt enters sleep; level from deep select and idle field.
// - Idle 0 stops CPU; 1 adds system bus; 2 adds peripheral bus.
// - Standby stops CPU, bus, main; oscillators per run-in-standby and on-request.
// - Wake sources per mode; idle 2 and standby only asynchronous.
// - Stopped domains halt regardless of mask bits.
// - Sleep-after-handler enters the selected sleep mode on return from lowest-priority handler.
// - Unmasked sufficient-priority interrupt wakes idle, restarting CPU and modules.
// - Failure flag stays set until software writes one to clear it.
`timescale 1ns/10ps
`include "pcrsm_defs.vh"
module pcrsm_power_manager
(
   input wire clock,
   input wire sys_rst,
   // Mask register writes.
   input wire ahbMaskWr,
   input wire [4:0] ahbMaskData,
   input wire apbaMaskWr,
   input wire [6:0] apbaMaskData,
   input wire apbbMaskWr,
   input wire [3:0] apbbMaskData,
   input wire apbcMaskWr,
   input wire [19:0] apbcMaskData,
   input wire apbaBridgeOn,
   output reg [4:0] system_bus_clock_mask_ff,
   output reg [6:0] apbaMask_ff,
   output reg [3:0] apbbMask_ff,
   output reg [19:0] apbcMask_ff,
   output wire [4:0] ahbClkEn,
   output wire [6:0] apbaClkEn,
   output wire [3:0] apbbClkEn,
   output wire [19:0] apbcClkEn,
   output wire maskLocked,
   // Clock failure detector.
   input wire clock_fail_detect_enable,
   input wire mainClkEdge,
   input wire refClkEdge,
   input wire mainClkReady,
   input wire backupClrWr,
   input wire clockFailFlagClr,
   input wire clockFailIntEn,
   output reg backup_clock_select_ff,
   output reg clock_fail_flag_ff,
   output wire clockFailIrq,
   // Reset sources.
   input wire porRst,
   input wire core_brownout_detector,
   input wire supply_brownout_detector,
   input wire resetPin_n,
   input wire wdtRst,
   input wire cpu_software_reset_request,
   output reg [7:0] reset_cause_register_ff,
   output wire powerDomainRst,
   output wire debugDomainRst,
   output wire userDomainRst,
   // Sleep controller.
   input wire wait_for_interrupt_instr,
   input wire handlerExitLowest,
   input wire sleep_after_handler,
   input wire deep_sleep_select,
   input wire [1:0] idleLevel,
   input wire run_in_standby,
   input wire on_request_only,
   input wire oscRequest,
   input wire syncAhbIrq,
   input wire syncApbIrq,
   input wire asyncIrq,
   output wire cpuClkEn,
   output wire ahbClkRun,
   output wire apbClkRun,
   output wire mainClkRun,
   output wire oscRun,
   output wire lowPowerMode,
   output wire sleeping
);

   localparam [2:0] ST_ACTIVE = 3'h0;
   localparam [2:0] ST_IDLE0 = 3'h1;
   localparam [2:0] ST_IDLE1 = 3'h2;
   localparam [2:0] ST_IDLE2 = 3'h3;
   localparam [2:0] ST_STANDBY = 3'h4;
   // Window is one reference period; failure is judged at each reference edge after the first one while monitoring.

   function isActive;
      input [2:0] st;
      begin
         isActive = (st == ST_ACTIVE);
      end
   endfunction

   // One-hot image of a reset cause bit position.
   function [7:0] causeBit;
      input [2:0] pos;
      begin
         causeBit = 8'h01 << pos;
      end
   endfunction

   reg [2:0] sleepState_ff;
   reg [2:0] nxt_sleepState;
   reg maskLock_ff;
   reg edgeSeen_ff;
   reg monitorArmed_ff;

   wire powerRst = porRst | core_brownout_detector | supply_brownout_detector;
   wire extRst = ~resetPin_n;
   wire userRst = wdtRst | cpu_software_reset_request;
   // Any sleep state stops the detector, so a slow wake never looks like a failure.
   wire monitoring = clock_fail_detect_enable & mainClkReady & isActive(sleepState_ff);
   wire failDetect = monitoring & monitorArmed_ff & refClkEdge & ~edgeSeen_ff & ~mainClkEdge;

   assign powerDomainRst = powerRst;
   assign debugDomainRst = powerRst | extRst;
   assign userDomainRst = powerRst | extRst | userRst;

   // mask write lock
   // The lock is one-way: with the manager's clock gone nothing could write it back.
   assign maskLocked = maskLock_ff;
   always @(posedge clock)
   begin
      if (sys_rst)
         maskLock_ff <= 1'b0;
      else if (~apbaMask_ff[`PCRSM_APBA_PM] | ~apbaBridgeOn)
         maskLock_ff <= 1'b1;
   end

   always @(posedge clock)
   begin
      if (sys_rst)
      begin
         system_bus_clock_mask_ff <= `PCRSM_AHB_RESET;
         apbaMask_ff <= `PCRSM_APBA_RESET;
         apbbMask_ff <= `PCRSM_APBB_RESET;
         apbcMask_ff <= `PCRSM_APBC_RESET;
      end
      else if (~maskLock_ff)
      begin
         // Writes while locked are dropped silently; nothing reports the refusal.
         // writing one restores
         if (ahbMaskWr)
            system_bus_clock_mask_ff <= ahbMaskData;
         if (apbaMaskWr)
            apbaMask_ff <= apbaMaskData;
         if (apbbMaskWr)
            apbbMask_ff <= apbbMaskData;
         if (apbcMaskWr)
            apbcMask_ff <= apbcMaskData;
      end
   end

   assign ahbClkEn = system_bus_clock_mask_ff & {5{ahbClkRun}};
   assign apbaClkEn = apbaMask_ff & {7{apbClkRun}};
   assign apbbClkEn = apbbMask_ff & {4{apbClkRun}};
   assign apbcClkEn = apbcMask_ff & {20{apbClkRun}};

   reg nxt_edgeSeen;
   reg nxt_monitorArmed;
   always @*
   begin
      nxt_edgeSeen = edgeSeen_ff;
      nxt_monitorArmed = monitorArmed_ff;
      if (~monitoring)
      begin
         // Disarming means the first partial window after enable is never judged.
         nxt_edgeSeen = 1'b0;
         nxt_monitorArmed = 1'b0;
      end
      else if (refClkEdge)
      begin
         nxt_edgeSeen = 1'b0;
         nxt_monitorArmed = 1'b1;
      end
      else if (mainClkEdge)
         nxt_edgeSeen = 1'b1;
   end

   always @(posedge clock)
   begin
      if (sys_rst)
      begin
         edgeSeen_ff <= 1'b0;
         monitorArmed_ff <= 1'b0;
      end
      else
      begin
         edgeSeen_ff <= nxt_edgeSeen;
         monitorArmed_ff <= nxt_monitorArmed;
      end
   end

   reg nxt_backupSel;
   reg nxt_failFlag;
   always @*
   begin
      nxt_backupSel = backup_clock_select_ff;
      nxt_failFlag = clock_fail_flag_ff;
      if (failDetect)
         nxt_backupSel = 1'b1;
      else if (backupClrWr)
         nxt_backupSel = 1'b0;
      if (failDetect)
         nxt_failFlag = 1'b1;
      else if (clockFailFlagClr)
         nxt_failFlag = 1'b0;
   end

   always @(posedge clock)
   begin
      if (sys_rst)
      begin
         backup_clock_select_ff <= 1'b0;
         clock_fail_flag_ff <= 1'b0;
      end
      else
      begin
         backup_clock_select_ff <= nxt_backupSel;
         clock_fail_flag_ff <= nxt_failFlag;
      end
   end

   assign clockFailIrq = clock_fail_flag_ff & clockFailIntEn;

   reg [7:0] nxt_resetCause;
   // reset cause
   // Not cleared by system reset, so boot code still sees why it restarted.
   always @*
   begin
      nxt_resetCause = reset_cause_register_ff;
      if (porRst)
         nxt_resetCause = `PCRSM_RC_RESET;
      else if (core_brownout_detector)
         nxt_resetCause = causeBit(`PCRSM_RC_CBOD);
      else if (supply_brownout_detector)
         nxt_resetCause = causeBit(`PCRSM_RC_SBOD);
      else if (extRst)
         nxt_resetCause = causeBit(`PCRSM_RC_EXT);
      else if (wdtRst)
         nxt_resetCause = causeBit(`PCRSM_RC_WDT);
      else if (cpu_software_reset_request)
         nxt_resetCause = causeBit(`PCRSM_RC_SYST);
   end

   always @(posedge clock)
   begin
      reset_cause_register_ff <= nxt_resetCause;
   end

   wire sleepReq = wait_for_interrupt_instr | (sleep_after_handler & handlerExitLowest);

   always @*
   begin
      nxt_sleepState = sleepState_ff;
      case (sleepState_ff)
         ST_ACTIVE:
         begin
            if (sleepReq)
            begin
               if (deep_sleep_select)
                  nxt_sleepState = ST_STANDBY;
               else if (idleLevel == 2'h0)
                  nxt_sleepState = ST_IDLE0;
               else if (idleLevel == 2'h1)
                  nxt_sleepState = ST_IDLE1;
               else
                  // Level 3 has no mode of its own and sleeps as idle 2.
                  nxt_sleepState = ST_IDLE2;
            end
         end
         ST_IDLE0:
            if (syncAhbIrq | syncApbIrq | asyncIrq)
               nxt_sleepState = ST_ACTIVE;
         ST_IDLE1:
            if (syncApbIrq | asyncIrq)
               nxt_sleepState = ST_ACTIVE;
         default:
            if (asyncIrq)
               nxt_sleepState = ST_ACTIVE;
      endcase
   end

   always @(posedge clock)
   begin
      if (sys_rst)
         sleepState_ff <= ST_ACTIVE;
      else
         sleepState_ff <= nxt_sleepState;
   end

   assign cpuClkEn = isActive(sleepState_ff);
   assign ahbClkRun = isActive(sleepState_ff) | (sleepState_ff == ST_IDLE0);
   assign apbClkRun = ahbClkRun | (sleepState_ff == ST_IDLE1);
   assign mainClkRun = (sleepState_ff != ST_STANDBY);
   assign oscRun = (sleepState_ff != ST_STANDBY) ?
                   (~on_request_only | oscRequest) :
                   (run_in_standby & (~on_request_only | oscRequest));
   assign lowPowerMode = (sleepState_ff == ST_STANDBY);
   assign sleeping = ~isActive(sleepState_ff);

endmodule // pcrsm_power_manager
